//--- logic/rcm_receive.sv
// Receive-data command interpreter with modem output setting and modem input gating.
// Assumes APB master on pclk, byte stream source and a host-memory byte write port.
`timescale 1ns/1ps

// Contract
// [RULE1] Command code 30 hex selects the receive-data operation.
// [RULE2] Length field gives buffer size, address field its host location.
// [RULE3] Host supplies one contiguous buffer; bytes are written sequentially.
// [RULE4] Response only when reception ends or an error occurs.
// [RULE5] Completion writes result status and overwrites length with bytes received.
// [RULE6] Options come in two 32-bit words: modem control and modem timeout.
// [RULE7] With change enabled, drive modem outputs from bits 4..0 before receiving.
// [RULE8] Host changes modem outputs in transmit or receive commands, not both.
// [RULE9] No fixed order between transmit and receive; incoming data decides.
// [RULE10] Modem output field applied only when bit 7 is set.
// [RULE11] Modem inputs checked only when bit 8 is set.
// [RULE12] Reception waits until modem inputs match required bits 15..9; with bit 16 clear the code compares no bit, so any inputs match.
// [RULE13] Required bits 9 and 11 are looped test inputs.
// [RULE14] Mask byte used only with bit 16; bits 17..23 enable bits 9..15.
// [RULE15] Wait limited by timeout bits 15..0 in 10 ms units.
// [RULE16] Unmet conditions at limit abandon command with timeout status.
// [RULE17] Timeout zero means wait forever, never time out.
// [RULE18] 10 ms tick from clock; load count at wait start, decrement per tick.
module rcm_receive #(
   parameter int unsigned TICK_CYCLES = rcm_pkg::RCM_TICK_CYCLES
) (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire rcm_pkg::rcm_apb_req_t            apb_req,
   output logic [31:0]                           prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic                             rx_valid,
   input  wire logic [7:0]                       rx_data,
   input  wire logic                             rx_last,
   output logic                                  rx_ready,
   output rcm_pkg::rcm_mem_wr_t                  mem_wr,
   input  wire logic                             mem_ready,
   input  wire logic [rcm_pkg::RCM_MIN_W-1:0]    modem_in,
   output logic [rcm_pkg::RCM_MOUT_W-1:0]        modem_out,
   output logic                                  busy,
   output logic                                  irq
);
   import rcm_pkg::*;

   // ----------------------------------------------------------
   // Types and state
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SET  = 2'b01,
      ST_WAIT = 2'b11,
      ST_RECV = 2'b10
   } rcm_fsm_t;

   typedef struct packed {
      rcm_fsm_t                 state;
      logic [7:0]               cmd;
      logic [31:0]              len;
      logic [31:0]              addr;
      logic [31:0]              pctl;
      logic [31:0]              ptmo;
      logic                     busy;
      rcm_result_t              result;
      logic [31:0]              rxcnt;
      logic                     last;
      logic [RCM_TMO_W-1:0]     tmo;
      logic [RCM_IRQ_W-1:0]     irq_stat;
      logic [RCM_IRQ_W-1:0]     irq_en;
      logic                     irq;
      logic [RCM_MOUT_W-1:0]    modem_out;
      logic                     rx_ready;
      rcm_mem_wr_t              mem;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
   } rcm_state_t;

   rcm_state_t           s_ff;
   rcm_state_t           nxt_s;
   logic                 tick;
   logic [RCM_IRQ_W-1:0] irq_set;
   logic [RCM_IRQ_W-1:0] irq_clr;

   // ----------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------

   // True for every register offset the block decodes
   function automatic logic addr_known(input logic [RCM_AW-1:0] a);
      return (a == RCM_OFF_CMD)      || (a == RCM_OFF_LEN)     ||
             (a == RCM_OFF_ADDR)     || (a == RCM_OFF_PCTL)    ||
             (a == RCM_OFF_PTMO)     || (a == RCM_OFF_CTRL)    ||
             (a == RCM_OFF_STATUS)   || (a == RCM_OFF_IRQ_STAT) ||
             (a == RCM_OFF_IRQ_CLR)  || (a == RCM_OFF_IRQ_EN)  ||
             (a == RCM_OFF_MODEM);
   endfunction : addr_known

   // Modem inputs agree with the required states on every significant bit
   function automatic logic modem_match(input logic [31:0] p,
                                        input logic [RCM_MIN_W-1:0] min);
      logic [RCM_MIN_W-1:0] req;
      logic [RCM_MIN_W-1:0] msk;
      req = p[RCM_MC_REQ_LSB +: RCM_MIN_W]; // [RULE12] [RULE13]
      msk = p[RCM_MC_MEN_BIT] ? p[RCM_MC_MASK_LSB +: RCM_MIN_W] : '0; // [RULE14]
      return ((min ^ req) & msk) == '0;
   endfunction : modem_match

   // Hand the command back: idle state, result and received length
   function automatic rcm_state_t finish(input rcm_state_t x, input rcm_result_t r);
      rcm_state_t y;
      y          = x;
      y.state    = ST_IDLE;
      y.busy     = 1'b0;
      y.result   = r;        // [RULE5]
      y.len      = x.rxcnt;  // [RULE5]
      y.rx_ready = 1'b0;
      return y;
   endfunction : finish

   // ----------------------------------------------------------
   // 10 ms tick, phase restarted outside the modem wait
   // ----------------------------------------------------------
   rcm_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (s_ff.state != ST_WAIT), // [RULE18]
      .tick    (tick)
   );

   // ----------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------

   // Bus slave, command sequencer, receive path and interrupts
   always_comb begin
      nxt_s         = s_ff;
      irq_set       = '0;
      irq_clr       = '0;
      nxt_s.pready  = 1'b0;
      nxt_s.pslverr = 1'b0;

      // Setup phase: decode and register the answer for the access phase
      if (apb_req.psel && !apb_req.penable) begin
         nxt_s.pready  = 1'b1;
         nxt_s.pslverr = !addr_known(apb_req.paddr);
         nxt_s.prdata  = RCM_RST_WORD;
         if (!apb_req.pwrite) begin
            unique case (apb_req.paddr)
               RCM_OFF_CMD:      nxt_s.prdata = {24'h0, s_ff.cmd};
               RCM_OFF_LEN:      nxt_s.prdata = s_ff.len;
               RCM_OFF_ADDR:     nxt_s.prdata = s_ff.addr;
               RCM_OFF_PCTL:     nxt_s.prdata = s_ff.pctl;
               RCM_OFF_PTMO:     nxt_s.prdata = s_ff.ptmo;
               RCM_OFF_STATUS:   nxt_s.prdata = {27'h0, s_ff.busy, s_ff.state, s_ff.result};
               RCM_OFF_IRQ_STAT: nxt_s.prdata = {{(32-RCM_IRQ_W){1'b0}}, s_ff.irq_stat};
               RCM_OFF_IRQ_EN:   nxt_s.prdata = {{(32-RCM_IRQ_W){1'b0}}, s_ff.irq_en};
               RCM_OFF_MODEM:    nxt_s.prdata = {20'h0, modem_in, s_ff.modem_out};
               default:          nxt_s.prdata = RCM_RST_WORD;
            endcase
         end
      end

      // Access phase completes: writes take effect; command block locked while busy
      if (apb_req.psel && apb_req.penable && s_ff.pready && apb_req.pwrite) begin
         unique case (apb_req.paddr)
            RCM_OFF_CMD:     if (!s_ff.busy) nxt_s.cmd = apb_req.pwdata[7:0];
            RCM_OFF_LEN:     if (!s_ff.busy) nxt_s.len = apb_req.pwdata;   // [RULE2]
            RCM_OFF_ADDR:    if (!s_ff.busy) nxt_s.addr = apb_req.pwdata;  // [RULE2]
            RCM_OFF_PCTL:    if (!s_ff.busy) nxt_s.pctl = apb_req.pwdata;  // [RULE6]
            RCM_OFF_PTMO:    if (!s_ff.busy) nxt_s.ptmo = apb_req.pwdata;  // [RULE6]
            RCM_OFF_IRQ_CLR: irq_clr = apb_req.pwdata[RCM_IRQ_W-1:0];
            RCM_OFF_IRQ_EN:  nxt_s.irq_en = apb_req.pwdata[RCM_IRQ_W-1:0];
            RCM_OFF_CTRL: begin
               if (!s_ff.busy && apb_req.pwdata[RCM_CTRL_GO_BIT]) begin
                  nxt_s.state  = ST_SET;
                  nxt_s.busy   = 1'b1;
                  nxt_s.result = RCM_RES_OK;
                  nxt_s.rxcnt  = '0;
               end
            end
            default: ;
         endcase
      end

      // Command sequencer
      unique case (s_ff.state)
         ST_IDLE: ;
         ST_SET: begin
            if (s_ff.cmd != RCM_CMD_RECEIVE) begin // [RULE1]
               nxt_s   = finish(nxt_s, RCM_RES_BADCMD); // [RULE4]
               irq_set[RCM_IRQ_DONE] = 1'b1;
            end else begin
               if (s_ff.pctl[RCM_MC_CHG_BIT]) begin // [RULE10]
                  nxt_s.modem_out = s_ff.pctl[RCM_MOUT_W-1:0]; // [RULE7]
               end
               if (s_ff.pctl[RCM_MC_CHK_BIT]) begin // [RULE11]
                  nxt_s.state = ST_WAIT;
                  nxt_s.tmo   = s_ff.ptmo[RCM_TMO_W-1:0]; // [RULE15] [RULE18]
               end else begin
                  nxt_s.state    = ST_RECV;
                  nxt_s.rx_ready = 1'b1;
                  nxt_s.last     = 1'b0;
               end
            end
         end
         ST_WAIT: begin
            if (modem_match(s_ff.pctl, modem_in)) begin // [RULE12]
               nxt_s.state    = ST_RECV;
               nxt_s.rx_ready = 1'b1;
               nxt_s.last     = 1'b0;
            end else if (tick && s_ff.tmo != '0) begin // [RULE17]
               if (s_ff.tmo == RCM_TMO_W'(1)) begin
                  nxt_s = finish(nxt_s, RCM_RES_TIMEOUT); // [RULE16]
                  irq_set[RCM_IRQ_DONE] = 1'b1;
                  irq_set[RCM_IRQ_TMO]  = 1'b1;
               end else begin
                  nxt_s.tmo = s_ff.tmo - RCM_TMO_W'(1); // [RULE18]
               end
            end
         end
         ST_RECV: begin
            // Bytes are taken as they arrive, independent of any transmit work
            if (s_ff.mem.valid) begin
               if (mem_ready) begin
                  nxt_s.mem.valid = 1'b0;
                  if (s_ff.last) begin
                     nxt_s = finish(nxt_s, RCM_RES_OK); // [RULE4] [RULE9]
                     irq_set[RCM_IRQ_DONE] = 1'b1;
                  end else begin
                     nxt_s.rx_ready = 1'b1;
                  end
               end
            end else if (s_ff.rx_ready && rx_valid) begin
               nxt_s.rx_ready = 1'b0;
               if (s_ff.rxcnt >= s_ff.len) begin
                  nxt_s = finish(nxt_s, RCM_RES_OVERRUN); // [RULE4]
                  irq_set[RCM_IRQ_DONE] = 1'b1;
               end else begin
                  nxt_s.mem.valid = 1'b1;
                  nxt_s.mem.addr  = s_ff.addr + s_ff.rxcnt; // [RULE2] [RULE3]
                  nxt_s.mem.data  = rx_data;
                  nxt_s.last      = rx_last;
                  nxt_s.rxcnt     = s_ff.rxcnt + 32'd1;
               end
            end
         end
      endcase

      // Sticky status: a set in the same cycle as a clear wins
      nxt_s.irq_stat = (s_ff.irq_stat & ~irq_clr) | irq_set;
      nxt_s.irq      = |(nxt_s.irq_stat & nxt_s.irq_en);
   end

   // ----------------------------------------------------------
   // State register
   // ----------------------------------------------------------

   // All block state except the u_tick counter in one register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------

   // Every output straight from the state register
   assign prdata    = s_ff.prdata;
   assign pready    = s_ff.pready;
   assign pslverr   = s_ff.pslverr;
   assign rx_ready  = s_ff.rx_ready;
   assign mem_wr    = s_ff.mem;
   assign modem_out = s_ff.modem_out;
   assign busy      = s_ff.busy;
   assign irq       = s_ff.irq;

endmodule : rcm_receive

//--- common/rcm_pkg.sv
// Shared constants and types for the receive command block.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
package rcm_pkg;

   // ----------------------------------------------------------
   // Command and timing
   // ----------------------------------------------------------
   localparam logic [7:0]  RCM_CMD_RECEIVE  = 8'h30;
   localparam int unsigned RCM_TICK_NS      = 10_000_000; // 10 ms
   localparam int unsigned RCM_PCLK_NS      = 5;          // 200 MHz
   localparam int unsigned RCM_TICK_CYCLES  = RCM_TICK_NS / RCM_PCLK_NS;

   // ----------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------
   localparam int unsigned RCM_AW           = 8;
   localparam logic [7:0]  RCM_OFF_CMD      = 8'h00;
   localparam logic [7:0]  RCM_OFF_LEN      = 8'h04;
   localparam logic [7:0]  RCM_OFF_ADDR     = 8'h08;
   localparam logic [7:0]  RCM_OFF_PCTL     = 8'h0c;
   localparam logic [7:0]  RCM_OFF_PTMO     = 8'h10;
   localparam logic [7:0]  RCM_OFF_CTRL     = 8'h14;
   localparam logic [7:0]  RCM_OFF_STATUS   = 8'h18;
   localparam logic [7:0]  RCM_OFF_IRQ_STAT = 8'h1c;
   localparam logic [7:0]  RCM_OFF_IRQ_CLR  = 8'h20;
   localparam logic [7:0]  RCM_OFF_IRQ_EN   = 8'h24;
   localparam logic [7:0]  RCM_OFF_MODEM    = 8'h28;
   localparam logic [31:0] RCM_RST_WORD     = 32'h0000_0000;
   localparam int unsigned RCM_CTRL_GO_BIT  = 0;

   // ----------------------------------------------------------
   // Parameter word fields
   // ----------------------------------------------------------
   localparam int unsigned RCM_MOUT_W       = 5;  // New modem outputs <4:0>
   localparam int unsigned RCM_MIN_W        = 7;  // Modem inputs <15:9>
   localparam int unsigned RCM_MC_CHG_BIT   = 7;
   localparam int unsigned RCM_MC_CHK_BIT   = 8;
   localparam int unsigned RCM_MC_REQ_LSB   = 9;
   localparam int unsigned RCM_MC_MEN_BIT   = 16;
   localparam int unsigned RCM_MC_MASK_LSB  = 17;
   localparam int unsigned RCM_TMO_W        = 16; // Timeout <15:0>

   // ----------------------------------------------------------
   // Interrupt bits and results
   // ----------------------------------------------------------
   localparam int unsigned RCM_IRQ_W        = 2;
   localparam int unsigned RCM_IRQ_DONE     = 0;
   localparam int unsigned RCM_IRQ_TMO      = 1;

   typedef enum logic [1:0] {
      RCM_RES_OK      = 2'h0,
      RCM_RES_TIMEOUT = 2'h1,
      RCM_RES_OVERRUN = 2'h2,
      RCM_RES_BADCMD  = 2'h3
   } rcm_result_t;

   // APB request from the master
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [RCM_AW-1:0] paddr;
      logic [31:0]       pwdata;
   } rcm_apb_req_t;

   // Byte write into host memory
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic [7:0]  data;
   } rcm_mem_wr_t;

endpackage : rcm_pkg

//--- logic/rcm_tick.sv
// Restartable 10 ms tick generator for the modem wait timer, held at phase zero while restart is high.
// Assumes restart is synchronous to pclk.
`timescale 1ns/1ps
module rcm_tick #(
   parameter int unsigned TICK_CYCLES = rcm_pkg::RCM_TICK_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic restart,
   output logic      tick
);
   import rcm_pkg::*;

   localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } rcm_tick_st_t;

   rcm_tick_st_t tk_ff;
   rcm_tick_st_t nxt_tk;

   // ----------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------
   if (TICK_CYCLES < 2) begin : g_bad
      $error("TICK_CYCLES must be at least 2");
   end

   // Count cycles, pulse once per period, restart clears phase
   always_comb begin
      nxt_tk      = tk_ff;
      nxt_tk.tick = 1'b0;
      if (restart) begin
         nxt_tk.cnt = '0;
      end else if (tk_ff.cnt == CW'(TICK_CYCLES - 1)) begin
         nxt_tk.cnt  = '0;
         nxt_tk.tick = 1'b1; // [RULE18]
      end else begin
         nxt_tk.cnt = tk_ff.cnt + CW'(1);
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tk_ff <= '0;
      end else begin
         tk_ff <= nxt_tk;
      end
   end

   assign tick = tk_ff.tick;

endmodule : rcm_tick

//--- bench/rcm_receive_properties.sv
// Port-level assertions for the receive command block.
// Assumes one pclk domain; bound to rcm_receive from the bench top.
`timescale 1ns/1ps
module rcm_receive_properties #(
   parameter int unsigned TICK_CYCLES = rcm_pkg::RCM_TICK_CYCLES
) (
   input wire logic                            pclk,
   input wire logic                            presetn,
   input wire rcm_pkg::rcm_apb_req_t           apb_req,
   input wire logic [31:0]                     prdata,
   input wire logic                            pready,
   input wire logic                            pslverr,
   input wire logic                            rx_valid,
   input wire logic [7:0]                      rx_data,
   input wire logic                            rx_last,
   input wire logic                            rx_ready,
   input wire rcm_pkg::rcm_mem_wr_t            mem_wr,
   input wire logic                            mem_ready,
   input wire logic [rcm_pkg::RCM_MIN_W-1:0]   modem_in,
   input wire logic [rcm_pkg::RCM_MOUT_W-1:0]  modem_out,
   input wire logic                            busy,
   input wire logic                            irq
);
   import rcm_pkg::*;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   AST_PREADY_SETUP: assert property (apb_req.psel && !apb_req.penable |=> pready) else $error("no pready");
   AST_PREADY_ONE: assert property (pready |=> !pready) else $error("pready too long");
   AST_ERR_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_TAKE_WRITE: assert property (
      rx_valid && rx_ready |=> !busy || (mem_wr.valid && mem_wr.data == $past(rx_data)))
      else $error("taken byte not written");
   AST_WR_HOLD: assert property (mem_wr.valid && !mem_ready |=> $stable(mem_wr)) else $error("write moved");
   AST_ONE_PENDING: assert property (mem_wr.valid |-> !rx_ready) else $error("byte taken while pending");
   AST_RX_BUSY: assert property (rx_ready |-> busy) else $error("rx_ready while idle");
   AST_END_CLEAN: assert property ($fell(busy) |-> !rx_ready && !mem_wr.valid) else $error("ended mid byte");
   AST_NEXT_BYTE: assert property (mem_wr.valid && mem_ready |=> rx_ready || !busy) else $error("stall");
   AST_MODEM_IDLE: assert property (!busy |=> $stable(modem_out)) else $error("modem out moved");

   // Main scenarios reached
   COV_DONE: cover property ($fell(busy));
   COV_STALL: cover property (mem_wr.valid && !mem_ready);
   COV_ERR: cover property (pslverr);
endmodule : rcm_receive_properties

//--- bench/rcm_mem_model.sv
// Host memory partner: stores byte writes and stalls at random.
// Assumes byte addresses wrap within a 256-byte window.
`timescale 1ns/1ps
module rcm_mem_model (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire rcm_pkg::rcm_mem_wr_t  mem_wr,
   output logic                       mem_ready
);
   import rcm_pkg::*;
   logic [7:0]  mem [256];
   logic [15:0] lfsr_ff;

   // One flat buffer; a byte lands only on a ready edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr_ff   <= 16'hace1;
         mem_ready <= 1'b0;
      end else begin
         lfsr_ff   <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
         mem_ready <= lfsr_ff[0] | lfsr_ff[3];
         if (mem_wr.valid && mem_ready) begin
            mem[mem_wr.addr[7:0]] <= mem_wr.data;
         end
      end
   end
endmodule : rcm_mem_model

//--- bench/tb.sv
// Self-checking bench for the receive command block.
// Assumes the package, memory model and property checker compile first.
`timescale 1ns/1ps
module tb;
   import rcm_pkg::*;
   localparam int unsigned TICKS = 8;
   logic         pclk, presetn, rx_valid, rx_last, mem_ready, pready, pslverr;
   logic         rx_ready, busy, irq, slv;
   logic [7:0]   rx_data;
   logic [7:0]   eb [8];
   logic [31:0]  prdata, q, seed, p1, adr;
   logic [6:0]   modem_in;
   logic [4:0]   modem_out, mout;
   rcm_apb_req_t req;
   rcm_mem_wr_t  mem_wr;
   int           mismatches, compares, cyc, n, len;

   rcm_receive #(.TICK_CYCLES(TICKS)) u_dut (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rx_ready(rx_ready), .mem_wr(mem_wr), .mem_ready(mem_ready), .modem_in(modem_in),
      .modem_out(modem_out), .busy(busy), .irq(irq));
   rcm_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_wr(mem_wr), .mem_ready(mem_ready));

   // Clock and hang guard
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         close_out();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Reception may start once every significant required bit matches
   function automatic logic match(input logic [31:0] p, input logic [6:0] m);
      return !p[8] || !p[16] || (((m ^ p[15:9]) & p[23:17]) == 7'h00);
   endfunction : match

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; q and slv keep what the answer carried
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      slv = pslverr;
      req <= '0;
      @(posedge pclk);
   endtask : apb

   // Offer one byte until taken, then show a changed value
   task automatic send(input logic [7:0] b, input logic l);
      rx_valid <= 1'b1;
      rx_data  <= b;
      rx_last  <= l;
      @(posedge pclk);
      while (rx_ready !== 1'b1) @(posedge pclk);
      rx_valid <= 1'b0;
      rx_data  <= ~b;
      @(posedge pclk);
   endtask : send

   task automatic idle();
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (busy !== 1'b0);
   endtask : idle

   task automatic run(input logic [7:0] c, input logic [31:0] l, a, w1, w2);
      apb(1'b1, RCM_OFF_CMD, {24'h0, c});
      apb(1'b1, RCM_OFF_LEN, l);
      apb(1'b1, RCM_OFF_ADDR, a);
      apb(1'b1, RCM_OFF_PCTL, w1);
      apb(1'b1, RCM_OFF_PTMO, w2);
      apb(1'b1, RCM_OFF_CTRL, 32'h1);
   endtask : run

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      req = '0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
      modem_in = 7'h00;
      seed = 32'hd25c;
      mout = 5'h00;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped address
      apb(1'b0, RCM_OFF_STATUS, 32'h0);
      chk(q, RCM_RST_WORD);
      apb(1'b1, 8'h2c, 32'hffff_ffff);
      chk(slv, 1'b1);
      apb(1'b0, 8'h2c, 32'h0);
      chk(q, 32'h0);
      // A wrong command code finishes with its own result
      apb(1'b1, RCM_OFF_IRQ_EN, 32'h1);
      run(8'h31, 32'h8, 32'h0, 32'h0, 32'h0);
      idle();
      apb(1'b0, RCM_OFF_STATUS, 32'h0);
      chk(q[1:0], RCM_RES_BADCMD);
      apb(1'b1, RCM_OFF_IRQ_CLR, 32'h3);
      // Receives over every setting of the change, check and mask-use bits
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         p1 = {8'h00, seed[23:18], 1'b1, i[2], seed[15:9], i[1:0], seed[6:0]};
         len = 1 + seed[26:24];
         adr = lfsr(seed);
         modem_in <= ~p1[15:9];
         if (p1[7]) mout = p1[4:0];
         run(RCM_CMD_RECEIVE, 32'h8, adr, p1, 32'h0);
         if (!match(p1, ~p1[15:9])) begin
            repeat (3 * TICKS) @(posedge pclk);
            chk({busy, rx_ready}, 2'b10);
            // Unmasked inputs stay wrong: only significant bits may gate
            modem_in <= p1[15:9] ^ ~p1[23:17];
         end
         for (int k = 0; k < len; k++) begin
            seed = lfsr(seed);
            eb[k] = seed[7:0];
            send(eb[k], k == len - 1);
         end
         idle();
         apb(1'b0, RCM_OFF_LEN, 32'h0);
         chk(q, len);
         apb(1'b0, RCM_OFF_STATUS, 32'h0);
         chk(q[4:0], RCM_RES_OK);
         chk(modem_out, mout);
         apb(1'b0, RCM_OFF_MODEM, 32'h0);
         chk(q, {20'h0, modem_in, mout});
         for (int k = 0; k < len; k++) chk(u_mem.mem[8'(adr[7:0] + k)], eb[k]);
         chk(irq, 1'b1);
         apb(1'b1, RCM_OFF_IRQ_CLR, 32'h1);
         apb(1'b0, RCM_OFF_IRQ_STAT, 32'h0);
         chk({irq, q[1:0]}, 3'b000);
      end
      // A wait that never matches gives up after three ticks
      apb(1'b1, RCM_OFF_IRQ_EN, 32'h3);
      modem_in <= 7'h00;
      run(RCM_CMD_RECEIVE, 32'h8, 32'h0, 32'h0003_0300, 32'h3);
      idle();
      chk(n >= 3 * TICKS && n <= 3 * TICKS + 8, 1'b1);
      apb(1'b0, RCM_OFF_STATUS, 32'h0);
      chk(q[1:0], RCM_RES_TIMEOUT);
      apb(1'b0, RCM_OFF_IRQ_STAT, 32'h0);
      chk({irq, q[1:0]}, 3'b111);
      apb(1'b1, RCM_OFF_IRQ_EN, 32'h0);
      apb(1'b0, RCM_OFF_LEN, 32'h0);
      chk({irq, q[7:0]}, 9'h000);
      apb(1'b1, RCM_OFF_IRQ_CLR, 32'h3);
      // A byte beyond the buffer ends the command and is not counted
      run(RCM_CMD_RECEIVE, 32'h2, 32'h40, 32'h0, 32'h0);
      for (int k = 0; k < 3; k++) send(8'ha0 + 8'(k), 1'b0);
      idle();
      apb(1'b0, RCM_OFF_LEN, 32'h0);
      chk(q, 32'h2);
      apb(1'b0, RCM_OFF_STATUS, 32'h0);
      chk(q[1:0], RCM_RES_OVERRUN);
      close_out();
   end
endmodule : tb

bind rcm_receive rcm_receive_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
   .rx_ready(rx_ready), .mem_wr(mem_wr), .mem_ready(mem_ready), .modem_in(modem_in),
   .modem_out(modem_out), .busy(busy), .irq(irq));
